// ---- hw/rhp_pkg.sv ----
// Constants, register map and state type for the root hub port logic
package rhp_pkg;

  // ==========================================================
  // Register offsets (byte addresses on APB)
  localparam logic [7:0] OFF_STATUS = 8'h00;
  localparam logic [7:0] OFF_MASK   = 8'h04;
  localparam logic [7:0] OFF_CONFIG = 8'h08;

  // ==========================================================
  // Status register fields: read meaning / write command
  localparam int unsigned B_CONNECT  = 0;  // Read connect, write 1 clears enable
  localparam int unsigned B_ENABLE   = 1;  // Read enable, write 1 sets enable
  localparam int unsigned B_SUSPEND  = 2;  // Read suspend, write 1 sets suspend
  localparam int unsigned B_OVERCUR  = 3;  // Read overcurrent, write 1 resumes
  localparam int unsigned B_RESET    = 4;  // Read reset active, write 1 starts reset
  localparam int unsigned B_POWER    = 8;  // Read power, write 1 powers on
  localparam int unsigned B_POWEROFF = 9;  // Write 1 powers off
  localparam int unsigned CHG_LSB    = 16;
  localparam int unsigned CHG_W      = 5;

  // Change flag indices, relative to CHG_LSB
  localparam int unsigned CI_CONN = 0;
  localparam int unsigned CI_EN   = 1;
  localparam int unsigned CI_SUSP = 2;
  localparam int unsigned CI_OC   = 3;
  localparam int unsigned CI_RST  = 4;

  // Config register fields
  localparam int unsigned CFG_FIXED  = 0;
  localparam int unsigned CFG_RESUME = 1;
  localparam int unsigned CFG_W      = 2;

  // ==========================================================
  // Reset values
  localparam logic [CHG_W-1:0] MASK_RST  = 5'h00;
  localparam logic [CFG_W-1:0] CFG_RST   = 2'h0;
  localparam logic             POWER_RST = 1'b0;

  // ==========================================================
  // Timing
  localparam int unsigned CLK_KHZ        = 40000;
  localparam int unsigned RESET_TIME_MS  = 10;
  localparam int unsigned RESUME_TIME_MS = 20;
  localparam int unsigned RESET_CYC      = RESET_TIME_MS * CLK_KHZ;
  localparam int unsigned RESUME_CYC     = RESUME_TIME_MS * CLK_KHZ;
  localparam int unsigned TMR_W          = 20;

  typedef enum logic [1:0] {
    PS_IDLE   = 2'b00,
    PS_RESET  = 2'b01,
    PS_RESUME = 2'b10
  } rhp_state_t;

endpackage : rhp_pkg

// ---- hw/rhp_tmr_if.sv ----
// Start/done handshake between port control and the interval timer
`timescale 1ns/1ps
interface rhp_tmr_if;
  logic start;
  logic is_reset;
  logic done;
  modport ctrl (output start, output is_reset, input done);
  modport tmr  (input start, input is_reset, output done);
endinterface : rhp_tmr_if

// ---- hw/rhp_sync.sv ----
// Three-stage pin synchroniser with agreement filter
`timescale 1ns/1ps
module rhp_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             sys_clk,
  input  wire logic             reset,
  input  wire logic [WIDTH-1:0] din,
  output logic      [WIDTH-1:0] dout
);
  logic [WIDTH-1:0] s1_r;
  logic [WIDTH-1:0] s2_r;
  logic [WIDTH-1:0] s3_r;
  logic [WIDTH-1:0] q_r;
  logic [WIDTH-1:0] q_nxt;

  genvar i;
  generate
    for (i = 0; i < WIDTH; i++)
    begin : g_bit
      // Accept a change only once stages two and three agree
      always_comb
      begin
        q_nxt[i] = (s2_r[i] == s3_r[i]) ? s3_r[i] : q_r[i];
      end
    end
  endgenerate

  always_ff @(posedge sys_clk or posedge reset)
  begin
    if (reset)
    begin
      s1_r <= '0;
      s2_r <= '0;
      s3_r <= '0;
      q_r  <= '0;
    end
    else
    begin
      s1_r <= din;
      s2_r <= s1_r;
      s3_r <= s2_r;
      q_r  <= q_nxt;
    end
  end

  assign dout = q_r;
endmodule : rhp_sync

// ---- hw/rhp_timer.sv ----
// Interval timer for port reset and resume signalling
`timescale 1ns/1ps
module rhp_timer #(
  parameter int unsigned RESET_CYC  = rhp_pkg::RESET_CYC,
  parameter int unsigned RESUME_CYC = rhp_pkg::RESUME_CYC
) (
  input  wire logic sys_clk,
  input  wire logic reset,
  rhp_tmr_if.tmr    tif
);
  logic [rhp_pkg::TMR_W-1:0] cnt_r;
  logic [rhp_pkg::TMR_W-1:0] cnt_nxt;
  logic                      run_r;
  logic                      run_nxt;
  logic                      done_r;
  logic                      done_nxt;

  always_comb
  begin
    cnt_nxt  = cnt_r;
    run_nxt  = run_r;
    done_nxt = 1'b0;
    if (tif.start)
    begin
      cnt_nxt = tif.is_reset ? rhp_pkg::TMR_W'(RESET_CYC - 1) : rhp_pkg::TMR_W'(RESUME_CYC - 1);
      run_nxt = 1'b1;
    end
    else if (run_r)
    begin
      if (cnt_r == '0)
      begin
        run_nxt  = 1'b0;
        done_nxt = 1'b1;
      end
      else
      begin
        cnt_nxt = cnt_r - 1'b1;
      end
    end
  end

  always_ff @(posedge sys_clk or posedge reset)
  begin
    if (reset)
    begin
      cnt_r  <= '0;
      run_r  <= 1'b0;
      done_r <= 1'b0;
    end
    else
    begin
      cnt_r  <= cnt_nxt;
      run_r  <= run_nxt;
      done_r <= done_nxt;
    end
  end

  assign tif.done = done_r;
endmodule : rhp_timer

// ---- hw/rhp_port_top.sv ----
// Root hub port status/control with APB register access
`timescale 1ns/1ps
module rhp_port_top #(
  parameter int unsigned RESET_CYC  = rhp_pkg::RESET_CYC,
  parameter int unsigned RESUME_CYC = rhp_pkg::RESUME_CYC
) (
  input  wire logic        sys_clk,
  input  wire logic        reset,
  input  wire logic [7:0]  paddr,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        dev_connect_pin,
  input  wire logic        overcurrent_pin,
  input  wire logic        dev_resume_pin,
  input  wire logic        bus_error,
  output logic             port_reset_drive,
  output logic             port_resume_drive,
  output logic             port_suspend_out,
  output logic             port_power_out,
  output logic             resume_to_hc,
  output logic             irq
);
  // ==========================================================
  // Declarations
  rhp_pkg::rhp_state_t       st_r, st_nxt;
  logic                      enabled_r, enabled_nxt;
  logic                      suspended_r, suspended_nxt;
  logic                      reset_act_r, reset_act_nxt;
  logic                      power_r, power_nxt;
  logic                      resume_ind_r, resume_ind_nxt;
  logic                      resume_drv_r, resume_drv_nxt;
  logic                      start_r, start_nxt;
  logic                      kind_r, kind_nxt;
  logic                      conn_prev_r, oc_prev_r;
  logic [rhp_pkg::CHG_W-1:0] chg_r, chg_nxt, chg_set, mask_r, mask_nxt;
  logic [rhp_pkg::CFG_W-1:0] cfg_r, cfg_nxt;
  logic                      irq_r, irq_nxt;
  logic [31:0]               prdata_r, prdata_nxt;
  logic                      pready_r, pready_nxt;
  logic                      slverr_r, slverr_nxt;
  logic [2:0]                pin_q;
  logic                      connect, oc_now, dev_resume;
  logic                      wr, wr_status, hw_dis, up_resume;
  logic [31:0]               status_word;

  rhp_tmr_if tif ();

  function automatic logic addr_hit(input logic [7:0] a, input logic [7:0] off);
    addr_hit = (a == off);
  endfunction : addr_hit

  // ==========================================================
  // Pin synchronisers and timer
  rhp_sync #(.WIDTH(3)) u_sync (
    .sys_clk (sys_clk),
    .reset   (reset),
    .din     ({dev_resume_pin, overcurrent_pin, dev_connect_pin}),
    .dout    (pin_q)
  );

  rhp_timer #(.RESET_CYC(RESET_CYC), .RESUME_CYC(RESUME_CYC)) u_tmr (
    .sys_clk (sys_clk),
    .reset   (reset),
    .tif     (tif)
  );

  assign tif.start    = start_r;
  assign tif.is_reset = kind_r;

  // ==========================================================
  // Port events
  assign connect    = cfg_r[rhp_pkg::CFG_FIXED] | pin_q[0];
  assign oc_now     = pin_q[1];
  assign dev_resume = pin_q[2];
  assign wr         = psel & penable & pready_r & pwrite;
  assign wr_status  = wr & addr_hit(paddr, rhp_pkg::OFF_STATUS);
  // Any fault, loss of device or power drops an enabled port
  assign hw_dis     = enabled_r & ((conn_prev_r & ~connect) | (oc_now & ~oc_prev_r)
                                   | ~power_r | bus_error);
  assign up_resume  = suspended_r & dev_resume & (st_r == rhp_pkg::PS_IDLE);

  // Status bits, never the last command value
  always_comb
  begin
    status_word                           = 32'h0000_0000;
    status_word[rhp_pkg::B_CONNECT]       = connect;
    status_word[rhp_pkg::B_ENABLE]        = enabled_r;
    status_word[rhp_pkg::B_SUSPEND]       = suspended_r;
    status_word[rhp_pkg::B_OVERCUR]       = oc_now;
    status_word[rhp_pkg::B_RESET]         = reset_act_r;
    status_word[rhp_pkg::B_POWER]         = power_r;
    status_word[rhp_pkg::CHG_LSB +: rhp_pkg::CHG_W] = chg_r;
  end

  // ==========================================================
  // Next state
  always_comb
  begin
    st_nxt         = st_r;
    enabled_nxt    = enabled_r;
    suspended_nxt  = suspended_r;
    reset_act_nxt  = reset_act_r;
    power_nxt      = power_r;
    resume_ind_nxt = resume_ind_r;
    start_nxt      = 1'b0;
    kind_nxt       = kind_r;
    chg_set        = '0;
    mask_nxt       = mask_r;
    cfg_nxt        = cfg_r;
    if (wr_status)
    begin
      if (pwdata[rhp_pkg::B_ENABLE])
      begin
        if (connect)
          enabled_nxt = 1'b1;
        else
          chg_set[rhp_pkg::CI_CONN] = 1'b1;
      end
      if (pwdata[rhp_pkg::B_SUSPEND])
      begin
        if (connect)
          suspended_nxt = 1'b1;
        else
          chg_set[rhp_pkg::CI_CONN] = 1'b1;
      end
      if (pwdata[rhp_pkg::B_RESET])
      begin
        if (!connect)
          chg_set[rhp_pkg::CI_CONN] = 1'b1;
        else if (st_r == rhp_pkg::PS_IDLE)
        begin
          reset_act_nxt = 1'b1;
          st_nxt        = rhp_pkg::PS_RESET;
          start_nxt     = 1'b1;
          kind_nxt      = 1'b1;
        end
      end
      if (pwdata[rhp_pkg::B_OVERCUR] && suspended_r && st_nxt == rhp_pkg::PS_IDLE)
      begin
        st_nxt    = rhp_pkg::PS_RESUME;
        start_nxt = 1'b1;
        kind_nxt  = 1'b0;
      end
      if (pwdata[rhp_pkg::B_CONNECT])
        enabled_nxt = 1'b0;
      if (pwdata[rhp_pkg::B_POWER])
        power_nxt = 1'b1;
      if (pwdata[rhp_pkg::B_POWEROFF])
        power_nxt = 1'b0;
    end
    // Device-driven resume only from an idle suspended port
    if (up_resume && st_nxt == rhp_pkg::PS_IDLE)
    begin
      st_nxt         = rhp_pkg::PS_RESUME;
      start_nxt      = 1'b1;
      kind_nxt       = 1'b0;
      resume_ind_nxt = 1'b1;
    end
    unique case (st_r)
      rhp_pkg::PS_IDLE:
      begin
      end
      rhp_pkg::PS_RESET:
        if (tif.done)
        begin
          reset_act_nxt            = 1'b0;
          suspended_nxt            = 1'b0;
          enabled_nxt              = 1'b1;
          chg_set[rhp_pkg::CI_RST] = 1'b1;
          st_nxt                   = rhp_pkg::PS_IDLE;
        end
      rhp_pkg::PS_RESUME:
        if (tif.done)
        begin
          suspended_nxt             = 1'b0;
          enabled_nxt               = 1'b1;
          chg_set[rhp_pkg::CI_SUSP] = 1'b1;
          resume_ind_nxt            = 1'b0;
          st_nxt                    = rhp_pkg::PS_IDLE;
        end
      default:
        st_nxt = rhp_pkg::PS_IDLE;
    endcase
    if (cfg_r[rhp_pkg::CFG_RESUME])
      suspended_nxt = 1'b0;
    if (hw_dis)
    begin
      enabled_nxt             = 1'b0;
      chg_set[rhp_pkg::CI_EN] = 1'b1;
    end
    if (oc_now != oc_prev_r)
      chg_set[rhp_pkg::CI_OC] = 1'b1;
    if (connect != conn_prev_r)
      chg_set[rhp_pkg::CI_CONN] = 1'b1;
    // A new event beats a same-cycle write-one clear
    chg_nxt = chg_r | chg_set;
    if (wr_status)
      chg_nxt = (chg_r & ~pwdata[rhp_pkg::CHG_LSB +: rhp_pkg::CHG_W]) | chg_set;
    if (wr && addr_hit(paddr, rhp_pkg::OFF_MASK))
      mask_nxt = pwdata[rhp_pkg::CHG_LSB +: rhp_pkg::CHG_W];
    if (wr && addr_hit(paddr, rhp_pkg::OFF_CONFIG))
      cfg_nxt = pwdata[rhp_pkg::CFG_W-1:0];
    irq_nxt = |(chg_nxt & mask_nxt);
    // Registered, so a reset start never flashes resume onto the line
    resume_drv_nxt = (st_nxt == rhp_pkg::PS_RESUME) & suspended_nxt;
  end

  // ==========================================================
  // APB slave: one wait-free access phase, data staged in setup
  always_comb
  begin
    pready_nxt = psel & ~penable & ~pready_r;
    prdata_nxt = prdata_r;
    slverr_nxt = 1'b0;
    if (psel && !penable)
    begin
      slverr_nxt = ~(addr_hit(paddr, rhp_pkg::OFF_STATUS) | addr_hit(paddr, rhp_pkg::OFF_MASK)
                     | addr_hit(paddr, rhp_pkg::OFF_CONFIG));
      prdata_nxt = 32'h0000_0000;
      if (addr_hit(paddr, rhp_pkg::OFF_STATUS))
        prdata_nxt = status_word;
      else if (addr_hit(paddr, rhp_pkg::OFF_MASK))
        prdata_nxt[rhp_pkg::CHG_LSB +: rhp_pkg::CHG_W] = mask_r;
      else if (addr_hit(paddr, rhp_pkg::OFF_CONFIG))
        prdata_nxt[rhp_pkg::CFG_W-1:0] = cfg_r;
    end
  end

  always_ff @(posedge sys_clk or posedge reset)
  begin
    if (reset)
    begin
      st_r         <= rhp_pkg::PS_IDLE;
      enabled_r    <= 1'b0;
      suspended_r  <= 1'b0;
      reset_act_r  <= 1'b0;
      power_r      <= rhp_pkg::POWER_RST;
      resume_ind_r <= 1'b0;
      resume_drv_r <= 1'b0;
      start_r      <= 1'b0;
      kind_r       <= 1'b0;
      conn_prev_r  <= 1'b0;
      oc_prev_r    <= 1'b0;
      chg_r        <= '0;
      mask_r       <= rhp_pkg::MASK_RST;
      cfg_r        <= rhp_pkg::CFG_RST;
      irq_r        <= 1'b0;
      prdata_r     <= 32'h0000_0000;
      pready_r     <= 1'b0;
      slverr_r     <= 1'b0;
    end
    else
    begin
      st_r         <= st_nxt;
      enabled_r    <= enabled_nxt;
      suspended_r  <= suspended_nxt;
      reset_act_r  <= reset_act_nxt;
      power_r      <= power_nxt;
      resume_ind_r <= resume_ind_nxt;
      resume_drv_r <= resume_drv_nxt;
      start_r      <= start_nxt;
      kind_r       <= kind_nxt;
      conn_prev_r  <= connect;
      oc_prev_r    <= oc_now;
      chg_r        <= chg_nxt;
      mask_r       <= mask_nxt;
      cfg_r        <= cfg_nxt;
      irq_r        <= irq_nxt;
      prdata_r     <= prdata_nxt;
      pready_r     <= pready_nxt;
      slverr_r     <= slverr_nxt;
    end
  end

  assign prdata            = prdata_r;
  assign pready            = pready_r;
  assign pslverr           = slverr_r;
  assign port_reset_drive  = reset_act_r;
  assign port_resume_drive = resume_drv_r;
  assign port_suspend_out  = suspended_r;
  assign port_power_out    = power_r;
  assign resume_to_hc      = resume_ind_r;
  assign irq               = irq_r;

  // ==========================================================
  // Assertions
  property p_set_suspend;
    @(posedge sys_clk) disable iff (reset)
    wr_status && pwdata[rhp_pkg::B_SUSPEND] && connect && st_r == rhp_pkg::PS_IDLE
      && !cfg_r[rhp_pkg::CFG_RESUME] |=> suspended_r;
  endproperty
  a_set_suspend: assert property (p_set_suspend) else $error("suspend not set");

  property p_resume_end;
    @(posedge sys_clk) disable iff (reset)
    st_r == rhp_pkg::PS_RESUME && tif.done
      |=> !suspended_r && chg_r[rhp_pkg::CI_SUSP] && enabled_r == !$past(hw_dis);
  endproperty
  a_resume_end: assert property (p_resume_end) else $error("resume end wrong");

  property p_suspend_refused;
    @(posedge sys_clk) disable iff (reset)
    wr_status && pwdata[rhp_pkg::B_SUSPEND] && !connect && !suspended_r
      |=> !suspended_r && chg_r[rhp_pkg::CI_CONN];
  endproperty
  a_suspend_refused: assert property (p_suspend_refused) else $error("bad suspend");

  property p_ctrl_resume;
    @(posedge sys_clk) disable iff (reset)
    cfg_r[rhp_pkg::CFG_RESUME] |=> !suspended_r;
  endproperty
  a_ctrl_resume: assert property (p_ctrl_resume) else $error("suspend held");

  property p_up_resume;
    @(posedge sys_clk) disable iff (reset)
    up_resume |=> resume_to_hc && st_r == rhp_pkg::PS_RESUME;
  endproperty
  a_up_resume: assert property (p_up_resume) else $error("resume not passed");

  property p_read_status;
    @(posedge sys_clk) disable iff (reset)
    psel && !penable && addr_hit(paddr, rhp_pkg::OFF_STATUS)
      |=> prdata[rhp_pkg::B_ENABLE] == $past(enabled_r)
          && prdata[rhp_pkg::B_CONNECT] == $past(connect) && pready;
  endproperty
  a_read_status: assert property (p_read_status) else $error("status read wrong");

  property p_hw_disable;
    @(posedge sys_clk) disable iff (reset)
    hw_dis |=> !enabled_r && chg_r[rhp_pkg::CI_EN];
  endproperty
  a_hw_disable: assert property (p_hw_disable) else $error("hw disable wrong");

  property p_enable_refused;
    @(posedge sys_clk) disable iff (reset)
    wr_status && pwdata[rhp_pkg::B_ENABLE] && !connect |=> chg_r[rhp_pkg::CI_CONN];
  endproperty
  a_enable_refused: assert property (p_enable_refused) else $error("bad enable");

  property p_clear_enable;
    @(posedge sys_clk) disable iff (reset)
    wr_status && pwdata[rhp_pkg::B_CONNECT] && !tif.done |=> !enabled_r;
  endproperty
  a_clear_enable: assert property (p_clear_enable) else $error("enable kept");

  property p_fixed;
    @(posedge sys_clk) disable iff (reset)
    psel && !penable && addr_hit(paddr, rhp_pkg::OFF_STATUS) && cfg_r[rhp_pkg::CFG_FIXED]
      |=> prdata[rhp_pkg::B_CONNECT];
  endproperty
  a_fixed: assert property (p_fixed) else $error("fixed port disconnected");

  property p_reset_seq;
    @(posedge sys_clk) disable iff (reset)
    $rose(reset_act_r) |-> start_r && kind_r ##1 reset_act_r [*8];
  endproperty
  a_reset_seq: assert property (p_reset_seq) else $error("reset too short");

endmodule : rhp_port_top

// ---- verif/rhp_dev_model.sv ----
// Behavioural model of a device attached to the downstream port
`timescale 1ns/1ps
module rhp_dev_model (
  input  wire logic sys_clk,
  input  wire logic attach,
  input  wire logic wake,
  input  wire logic port_suspend_out,
  output logic      dev_connect_pin,
  output logic      dev_resume_pin
);
  int wake_cnt = 0;
  // ==========================================================
  // Resume signalling
  // Only a suspended port sees a device wake up
  always @(posedge sys_clk)
  begin
    if (wake && port_suspend_out)
      wake_cnt <= 8;
    else if (wake_cnt > 0)
      wake_cnt <= wake_cnt - 1;
  end
  assign dev_connect_pin = attach;
  // Line is pulled down once released
  assign dev_resume_pin  = attach && (wake_cnt > 0);
endmodule : rhp_dev_model

// ---- verif/tb_top.sv ----
// Self-checking testbench for the root hub port logic
`timescale 1ns/1ps
module tb_top;
  localparam int unsigned  RC = 16;
  localparam int unsigned  RS = 32;
  localparam logic [31:0]  MK = 32'h0014011F;
  logic        sys_clk = 1'b0, reset = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h00000000, prdata, q, rv, seed = 32'h0000A739;
  logic        pready, pslverr, e, ocp = 1'b0, bus_error = 1'b0, attach = 1'b0, wake = 1'b0;
  logic        con_pin, res_pin, rst_drv, susp_out, resume_to_hc, irq, rdrv, pwr_out;
  int          error_cnt = 0, check_count = 0, cyc = 0, k;
  int          m_conn = 0, m_fix = 0, m_en = 0, m_susp = 0, m_rst = 0, m_pwr = 0, m_chg = 0;

  initial forever #12.5 sys_clk = ~sys_clk;

  rhp_port_top #(.RESET_CYC(RC), .RESUME_CYC(RS)) uut (
    .sys_clk(sys_clk), .reset(reset), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .dev_connect_pin(con_pin), .overcurrent_pin(ocp), .dev_resume_pin(res_pin),
    .bus_error(bus_error), .port_reset_drive(rst_drv), .port_resume_drive(rdrv),
    .port_suspend_out(susp_out), .port_power_out(pwr_out), .resume_to_hc(resume_to_hc),
    .irq(irq));

  rhp_dev_model dev (.sys_clk(sys_clk), .attach(attach), .wake(wake),
    .port_suspend_out(susp_out), .dev_connect_pin(con_pin), .dev_resume_pin(res_pin));

  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : xs

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : report_and_stop

  always @(posedge sys_clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      error_cnt++;
      $display("FAIL %0t timeout", $time);
      report_and_stop();
    end
  end

  // ==========================================================
  // Bus cycles and comparisons
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    // Ends when pready is seen high; only the bench timeout ends a wait that never sees it
    do @(posedge sys_clk); while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    // Idle cycle lets write effects land before the next read
    @(posedge sys_clk);
  endtask : apb

  task automatic chk_w(input logic [31:0] got, input logic [31:0] exp, input string s);
    check_count++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("FAIL %0t %s got %h exp %h", $time, s, got, exp);
    end
  endtask : chk_w

  task automatic chk_st(input logic [31:0] m);
    logic [31:0] x;
    x = (m_chg << 16) | (m_pwr << 8) | (m_rst << 4) | (m_susp << 2) | (m_en << 1)
        | (m_conn | m_fix);
    apb(1'b0, rhp_pkg::OFF_STATUS, 32'h0);
    chk_w(q & m, x & m, "status");
  endtask : chk_st

  task automatic wr_st(input logic [31:0] d);
    int c;
    c = m_conn | m_fix;
    apb(1'b1, rhp_pkg::OFF_STATUS, d);
    if (d[0]) m_en = 0;
    if (d[1]) if (c != 0 && m_pwr != 0) m_en = 1; else if (c == 0) m_chg |= 1;
    if (d[2]) if (c != 0) m_susp = 1; else m_chg |= 1;
    if (d[4]) if (c != 0) m_rst = 1; else m_chg |= 1;
    if (d[8]) m_pwr = 1;
    if (d[9]) begin m_pwr = 0; m_en = 0; end
    m_chg &= ~int'(d[20:16]);
  endtask : wr_st

  task automatic wait_cyc(input int n);
    repeat (n) @(posedge sys_clk);
  endtask : wait_cyc

  task automatic done(input string s);
    $display("test %s done", s);
  endtask : done

  // ==========================================================
  // Main sequence
  initial
  begin
    wait_cyc(10);
    reset <= 1'b0;
    wait_cyc(5);
    chk_st(32'hFFFFFFFF);
    apb(1'b0, 8'h0C, 32'h0);
    chk_w({31'h0, e}, 32'h1, "unmapped error");
    chk_w(q, 32'h0, "unmapped data");
    for (k = 0; k < 8; k++)
    begin
      rv = xs();
      apb(1'b1, rhp_pkg::OFF_MASK, rv);
      apb(1'b0, rhp_pkg::OFF_MASK, 32'h0);
      chk_w(q, rv & 32'h001F0000, "mask readback");
    end
    apb(1'b1, rhp_pkg::OFF_MASK, 32'h0);
    done("reset and map");
    // No device: each enable, suspend or reset command only flags a connect change
    wr_st(32'h00000100);
    chk_w({31'h0, pwr_out}, 32'h1, "power on");
    for (k = 0; k < 3; k++)
    begin
      wr_st(32'h1 << (k == 2 ? 4 : k + 1));
      chk_st(MK | 32'h00010000);
      wr_st(32'h00010000);
    end
    done("disconnected commands");
    attach <= 1'b1;
    wait_cyc(8);
    m_conn = 1;
    wr_st(32'h001F0000);
    wr_st(32'h0);
    chk_st(MK);
    wr_st(32'h2);
    chk_st(MK);
    wr_st(32'h1);
    chk_st(MK);
    wr_st(32'h4);
    chk_st(MK);
    wr_st(32'h10);
    chk_st(MK);
    chk_w({31'h0, rst_drv}, 32'h1, "reset drive");
    wait_cyc(RC + 12);
    m_rst = 0;
    m_susp = 0;
    m_en = 1;
    m_chg |= 16;
    chk_st(MK);
    done("enable and reset");
    apb(1'b1, rhp_pkg::OFF_MASK, 32'h00100000);
    wait_cyc(2);
    chk_w({31'h0, irq}, 32'h1, "irq raised");
    apb(1'b1, rhp_pkg::OFF_MASK, 32'h0);
    wait_cyc(2);
    chk_w({31'h0, irq}, 32'h0, "irq masked");
    apb(1'b1, rhp_pkg::OFF_MASK, 32'h00100000);
    wr_st(32'h001F0000);
    wait_cyc(2);
    chk_w({31'h0, irq}, 32'h0, "irq cleared");
    apb(1'b1, rhp_pkg::OFF_MASK, 32'h0);
    done("interrupt");
    wr_st(32'h4);
    chk_w({31'h0, susp_out}, 32'h1, "suspend out");
    wake <= 1'b1;
    @(posedge sys_clk);
    wake <= 1'b0;
    k = 0;
    while (resume_to_hc !== 1'b1 && k < 20)
    begin
      @(posedge sys_clk);
      k++;
    end
    chk_w({31'h0, resume_to_hc}, 32'h1, "resume to controller");
    chk_w({31'h0, rdrv}, 32'h1, "resume drive");
    chk_st(MK);
    wait_cyc(RS + 20);
    chk_w({31'h0, rdrv}, 32'h0, "resume drive end");
    m_susp = 0;
    m_en = 1;
    m_chg |= 4;
    chk_st(MK);
    wr_st(32'h4);
    apb(1'b1, rhp_pkg::OFF_CONFIG, 32'h2);
    m_susp = 0;
    chk_st(MK);
    apb(1'b1, rhp_pkg::OFF_CONFIG, 32'h0);
    done("suspend and resume");
    // Faults: bus error, overcurrent, power off, disconnect
    for (k = 0; k < 4; k++)
    begin
      wr_st(32'h001F0100);
      wr_st(32'h2);
      if (k == 0) bus_error <= 1'b1;
      if (k == 1) ocp <= 1'b1;
      if (k == 3) attach <= 1'b0;
      if (k == 2) wr_st(32'h200);
      if (k == 2) chk_w({31'h0, pwr_out}, 32'h0, "power off");
      @(posedge sys_clk);
      bus_error <= 1'b0;
      wait_cyc(8);
      m_en = 0;
      m_chg |= 2;
      if (k == 3) m_conn = 0;
      chk_st(32'h00020002);
      ocp <= 1'b0;
      wait_cyc(8);
    end
    done("faults");
    apb(1'b1, rhp_pkg::OFF_CONFIG, 32'h1);
    m_fix = 1;
    chk_st(32'h1);
    apb(1'b1, rhp_pkg::OFF_CONFIG, 32'h0);
    m_fix = 0;
    chk_st(32'h1);
    done("fixed device");
    report_and_stop();
  end
endmodule : tb_top
